/* shared/ras_pkg.sv */
// constants and types for the return address stack block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package ras_pkg;
  localparam int PC_W = 21;
  localparam int SP_W = 5;
  localparam int DEPTH = 31;
  localparam logic [PC_W-1:0] RESET_VEC = 21'h00_0000;
  localparam logic [PC_W-1:0] INT_HI_VEC = 21'h00_0008;
  localparam logic [PC_W-1:0] INT_LO_VEC = 21'h00_0018;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [PC_W-1:0] MEM_4K = 21'h00_1000;
  localparam logic [PC_W-1:0] MEM_8K = 21'h00_2000;
  localparam logic [SP_W-1:0] SP_TOP = 5'h1f;
  localparam logic [SP_W-1:0] SP_ONE = 5'h01;
  // pointer register fields
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  // register byte addresses
  localparam logic [7:0] OFF_PTR_REG = 8'h00;
  localparam logic [7:0] OFF_TOS_UP = 8'h04;
  localparam logic [7:0] OFF_TOS_HI = 8'h08;
  localparam logic [7:0] OFF_TOS_LO = 8'h0c;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [31:0] CFG_RST = 32'h0000_0001;
  typedef enum logic [2:0] {OP_NONE, OP_CALL, OP_PUSH, OP_RET, OP_POP} stk_op_e;
  typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_e;
endpackage

/* logic/return_address_stack.sv */
// return address stack with pc, fetch gating and an axi4-lite register slave
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module return_address_stack
  import ras_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // core side
  input wire logic call_req,
  input wire logic int_ack,
  input wire logic int_hi,
  input wire logic ret_req,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic jump_req,
  input wire logic [20:0] jump_addr,
  input wire logic step,
  input wire logic [15:0] fetch_word_in,
  output logic [20:0] pc,
  output logic [15:0] fetch_word,
  output logic [20:0] data_addr,
  input wire logic [20:0] data_addr_in,
  output logic stack_fault_reset,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic full;
    logic unf;
    logic fault_en;
    logic mem8k;
    logic fault_rst;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] fetch;
  } st_s;

  st_s cur_ff;
  st_s nxt_ff;
  logic [PC_W-1:0] stack_mem [1:DEPTH];
  logic mem_we;
  logic [SP_W-1:0] mem_idx;
  logic [PC_W-1:0] mem_wd;
  logic [PC_W-1:0] tos;
  stk_op_e op;

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                        input logic en);
    merge8 = en ? nw : old;
  endfunction

  assign tos = (cur_ff.sp == '0) ? '0 : stack_mem[cur_ff.sp];

  always_comb begin
    if (call_req || int_ack) begin
      op = OP_CALL;
    end else if (ret_req) begin
      op = OP_RET;
    end else if (push_req) begin
      op = OP_PUSH;
    end else if (pop_req) begin
      op = OP_POP;
    end else begin
      op = OP_NONE;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [PC_W-1:0] ret_pc;
    logic [PC_W-1:0] lim;
    logic wr_fire;
    logic rd_fire;
    logic [SP_W-1:0] sp_inc;
    logic [PC_W-1:0] tw;
    logic hw_full;
    logic hw_unf;
    ret_pc = '0;
    hw_full = 1'b0;
    hw_unf = 1'b0;
    lim = '0;
    wr_fire = 1'b0;
    rd_fire = 1'b0;
    sp_inc = '0;
    tw = '0;
    nxt_ff = cur_ff;
    mem_we = 1'b0;
    mem_idx = cur_ff.sp;
    mem_wd = '0;
    nxt_ff.fault_rst = 1'b0;
    ret_pc = cur_ff.pc + PC_STEP;
    sp_inc = cur_ff.sp + SP_ONE;
    // hardware flag sets this cycle; they beat a software clear
    hw_full = (op == OP_CALL || op == OP_PUSH) && (cur_ff.sp == SP_TOP || sp_inc == SP_TOP);
    hw_unf = (op == OP_RET || op == OP_POP) && (cur_ff.sp == '0);
    lim = cur_ff.mem8k ? MEM_8K : MEM_4K;
    nxt_ff.fetch = (cur_ff.pc < lim) ? fetch_word_in : 16'h0000;
    if (step) begin
      nxt_ff.pc = ret_pc;
    end
    if (jump_req) begin
      nxt_ff.pc = jump_addr;
    end
    case (op)
      OP_CALL, OP_PUSH: begin
        if (cur_ff.sp == SP_TOP) begin
          nxt_ff.full = 1'b1;
        end else begin
          mem_we = 1'b1;
          mem_idx = sp_inc;
          mem_wd = (op == OP_PUSH) ? cur_ff.pc : ret_pc;
          nxt_ff.sp = sp_inc;
          if (sp_inc == SP_TOP) begin
            nxt_ff.full = 1'b1;
            if (cur_ff.fault_en) begin
              nxt_ff.sp = '0;
              nxt_ff.fault_rst = 1'b1;
              nxt_ff.pc = RESET_VEC;
            end
          end
        end
        if (op == OP_CALL && !cur_ff.fault_en | (sp_inc != SP_TOP)) begin
          if (int_ack) begin
            nxt_ff.pc = int_hi ? INT_HI_VEC : INT_LO_VEC;
          end else begin
            nxt_ff.pc = jump_addr;
          end
        end
      end
      OP_RET, OP_POP: begin
        if (cur_ff.sp == '0) begin
          nxt_ff.unf = 1'b1;
          if (op == OP_RET) begin
            nxt_ff.pc = RESET_VEC;
          end
        end else begin
          // load then decrement, pop leaves pc
          if (op == OP_RET) begin
            nxt_ff.pc = tos;
          end
          nxt_ff.sp = cur_ff.sp - SP_ONE;
        end
      end
      default: begin
      end
    endcase
    // ----------------------------------------------------------------
    // axi4-lite slave
    // ----------------------------------------------------------------
    s_axi_awready = !cur_ff.aw_got && !cur_ff.bvalid;
    s_axi_wready = !cur_ff.w_got && !cur_ff.bvalid;
    s_axi_arready = !cur_ff.rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_ff.aw_got = 1'b1;
      nxt_ff.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_ff.w_got = 1'b1;
      nxt_ff.w_data = s_axi_wdata;
      nxt_ff.w_strb = s_axi_wstrb;
    end
    wr_fire = cur_ff.aw_got && cur_ff.w_got;
    if (wr_fire) begin
      nxt_ff.aw_got = 1'b0;
      nxt_ff.w_got = 1'b0;
      nxt_ff.bvalid = 1'b1;
      nxt_ff.bresp = RESP_OK;
      tw = tos;
      case (cur_ff.aw_addr)
        OFF_PTR_REG: begin
          if (cur_ff.w_strb[0]) begin
            // pointer write, clear only, set wins
            if (op == OP_NONE) begin
              nxt_ff.sp = cur_ff.w_data[SP_W-1:0];
            end
            if (!cur_ff.w_data[FULL_BIT] && !hw_full) begin
              nxt_ff.full = 1'b0;
            end
            if (!cur_ff.w_data[UNF_BIT] && !hw_unf) begin
              nxt_ff.unf = 1'b0;
            end
          end
        end
        OFF_TOS_UP: tw[20:16] = 5'(merge8({3'b000, tos[20:16]}, cur_ff.w_data[7:0],
                                          cur_ff.w_strb[0]));
        OFF_TOS_HI: tw[15:8] = merge8(tos[15:8], cur_ff.w_data[7:0], cur_ff.w_strb[0]);
        OFF_TOS_LO: tw[7:0] = merge8(tos[7:0], cur_ff.w_data[7:0], cur_ff.w_strb[0]);
        OFF_CFG: begin
          if (cur_ff.w_strb[0]) begin
            nxt_ff.fault_en = cur_ff.w_data[0];
            nxt_ff.mem8k = cur_ff.w_data[1];
          end
        end
        OFF_STAT: begin
        end
        default: nxt_ff.bresp = RESP_ERR;
      endcase
      // only via these registers; core op has priority
      if (tw != tos && cur_ff.sp != '0 && !mem_we) begin
        mem_we = 1'b1;
        mem_idx = cur_ff.sp;
        mem_wd = tw;
      end
    end
    if (cur_ff.bvalid && s_axi_bready) begin
      nxt_ff.bvalid = 1'b0;
    end
    rd_fire = s_axi_arvalid && s_axi_arready;
    if (rd_fire) begin
      nxt_ff.rvalid = 1'b1;
      nxt_ff.rresp = RESP_OK;
      nxt_ff.rdata = '0;
      case (s_axi_araddr)
        OFF_PTR_REG: nxt_ff.rdata = {24'h00_0000, cur_ff.full, cur_ff.unf, 1'b0, cur_ff.sp};
        OFF_TOS_UP: nxt_ff.rdata = {27'h000_0000, tos[20:16]};
        OFF_TOS_HI: nxt_ff.rdata = {24'h00_0000, tos[15:8]};
        OFF_TOS_LO: nxt_ff.rdata = {24'h00_0000, tos[7:0]};
        OFF_CFG: nxt_ff.rdata = {30'h0000_0000, cur_ff.mem8k, cur_ff.fault_en};
        OFF_STAT: nxt_ff.rdata = {11'h000, cur_ff.pc};
        default: nxt_ff.rresp = RESP_ERR;
      endcase
    end else if (cur_ff.rvalid && s_axi_rready) begin
      nxt_ff.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset clears pointer; flags clear on this por or by a zero written to them in the pointer register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
      cur_ff.fault_en <= CFG_RST[0];
      cur_ff.pc <= RESET_VEC;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // memory has no reset; entries are dead until a push fills them
  always_ff @(posedge clk) begin
    if (mem_we) begin
      stack_mem[mem_idx] <= mem_wd;
    end
  end

  // pc out, no latch port, separate data port
  assign pc = cur_ff.pc;
  assign fetch_word = cur_ff.fetch;
  assign data_addr = data_addr_in;
  assign stack_fault_reset = cur_ff.fault_rst;
  assign s_axi_bvalid = cur_ff.bvalid;
  assign s_axi_bresp = cur_ff.bresp;
  assign s_axi_rvalid = cur_ff.rvalid;
  assign s_axi_rdata = cur_ff.rdata;
  assign s_axi_rresp = cur_ff.rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  logic wr_fire_w;
  assign wr_fire_w = cur_ff.aw_got && cur_ff.w_got;
  push_inc_a: assert property ((op == OP_PUSH && cur_ff.sp < 5'h1e) |=>
    cur_ff.sp == $past(cur_ff.sp) + 5'h01) else $error("push did not increment");
  pop_dec_a: assert property ((op == OP_POP && cur_ff.sp != '0) |=>
    cur_ff.sp == $past(cur_ff.sp) - 5'h01) else $error("pop did not decrement");
  unf_set_a: assert property ((op == OP_RET && cur_ff.sp == '0) |=>
    cur_ff.unf && cur_ff.pc == RESET_VEC && cur_ff.sp == '0) else $error("underflow");
  sat_top_a: assert property ((op == OP_PUSH && cur_ff.sp == SP_TOP) |=>
    cur_ff.sp == SP_TOP && cur_ff.full) else $error("saturation broken");
  ovf_rst_a: assert property ((op == OP_CALL && cur_ff.sp == 5'h1e && cur_ff.fault_en)
    |=> cur_ff.fault_rst && cur_ff.sp == '0 && cur_ff.full) else $error("overflow");
  full_stick_a: assert property ((cur_ff.full && !wr_fire_w) |=> cur_ff.full)
    else $error("full flag dropped");
  ptr_zero5_a: assert property (s_axi_rvalid && $past(s_axi_araddr == OFF_PTR_REG
    && s_axi_arvalid && s_axi_arready) |-> !s_axi_rdata[5]) else $error("bit5 set");
  ret_load_a: assert property ((op == OP_RET && cur_ff.sp != '0) |=>
    cur_ff.pc == $past(tos)) else $error("return pc wrong");
  call_c: cover property (op == OP_CALL ##[1:20] op == OP_RET);
  full_c: cover property (cur_ff.full);
  unf_c: cover property (cur_ff.unf);
  wr_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule // return_address_stack

/* tb/core_model.sv */
// core-side partner: op strobes, program memory image, data address
`timescale 1ns/10ps
module core_model
  import ras_pkg::*;
(
  input wire stk_op_e op,
  input wire logic irq,
  input wire logic [20:0] pc,
  output logic call_req,
  output logic int_ack,
  output logic ret_req,
  output logic push_req,
  output logic pop_req,
  output logic [15:0] fetch_word_in,
  output logic [20:0] data_addr_in
);
  assign call_req = (op == OP_CALL);
  assign int_ack = irq;
  assign ret_req = (op == OP_RET);
  assign push_req = (op == OP_PUSH);
  assign pop_req = (op == OP_POP);
  // memory never holds zero
  // so a gated fetch stands out
  assign fetch_word_in = {pc[15:1], 1'h1};
  assign data_addr_in = pc ^ 21'h15_5555;
endmodule // core_model

/* tb/test_return_address_stack.sv */
// self-checking bench for the return address stack
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); \
  end \
end
module test_return_address_stack
  import ras_pkg::*;
;
  logic clk, rst, irq, int_hi, jump_req, step, stack_fault_reset;
  logic call_req, int_ack, ret_req, push_req, pop_req;
  logic [20:0] jump_addr, pc, data_addr, data_addr_in, t, exp_q [1:31];
  logic [15:0] fetch_word_in, fetch_word;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, q, seed;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  stk_op_e op;
  int miscompares, comparisons, cyc, faults;

  return_address_stack dut_u (.*);
  core_model core_u (.*);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  always @(negedge clk) if (stack_fault_reset === 1'h1) faults++;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ptr_v(input logic f, input logic u, input logic [4:0] s);
    return {24'h00_0000, f, u, 1'h0, s};
  endfunction
  function automatic logic [15:0] mem(input logic [20:0] a);
    return {a[15:1], 1'h1};
  endfunction

  // sampled on the falling edge so the rising-edge handshake never races
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, pr, ta, tw, tr;
    pa = 1;
    pw = w;
    pr = 1;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (pr) begin
      @(negedge clk);
      ta = pa && (w ? s_axi_awready : s_axi_arready);
      tw = pw && s_axi_wready;
      tr = !pa && !pw && (w ? s_axi_bvalid : s_axi_rvalid);
      q = s_axi_rdata;
      rs = w ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (ta) begin
        s_axi_awvalid <= 0;
        s_axi_arvalid <= 0;
        pa = 0;
      end
      if (tw) begin
        s_axi_wvalid <= 0;
        pw = 0;
      end
      if (tr) begin
        s_axi_bready <= 0;
        s_axi_rready <= 0;
        pr = 0;
      end
    end
  endtask
  task automatic pchk(input logic f, input logic u, input logic [4:0] s);
    ax(0, OFF_PTR_REG, '0);
    `CHK("ptr reg", ptr_v(f, u, s), q)
  endtask
  task automatic tos_rd(output logic [20:0] v);
    ax(0, OFF_TOS_UP, '0);
    v[20:16] = q[4:0];
    ax(0, OFF_TOS_HI, '0);
    v[15:8] = q[7:0];
    ax(0, OFF_TOS_LO, '0);
    v[7:0] = q[7:0];
  endtask
  task automatic op_do(input stk_op_e o, input logic i, input logic j, input logic [20:0] a);
    op <= o;
    irq <= i;
    jump_req <= j;
    jump_addr <= a;
    @(posedge clk);
    op <= OP_NONE;
    irq <= 0;
    jump_req <= 0;
    @(posedge clk);
  endtask
  task automatic calls(input int n);
    for (int i = 1; i <= n; i++) begin
      exp_q[i] = pc + PC_STEP;
      op_do(OP_CALL, 0, 0, 21'(xs()) & 21'h1f_fffe);
    end
  endtask
  task automatic fchk(input logic [20:0] a, input logic [15:0] e);
    op_do(OP_NONE, 0, 1, a);
    @(negedge clk);
    `CHK("fetch", e, fetch_word)
    @(posedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------
  // main sequence
  // ----------------
  initial begin
    seed = 32'h0000_4340;
    {rst, irq, int_hi, jump_req, step, s_axi_awvalid, s_axi_wvalid} = 7'h01 << 6;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, jump_addr} = '0;
    s_axi_wstrb = 4'hf;
    op = OP_NONE;
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    pchk(0, 0, '0);
    ax(0, OFF_CFG, '0);
    `CHK("cfg", CFG_RST, q)
    `CHK("pc", RESET_VEC, pc)
    $display("reset test done");
    calls(8);
    pchk(0, 0, 5'h08);
    tos_rd(t);
    `CHK("tos", exp_q[8], t)
    for (int i = 8; i >= 1; i--) begin
      op_do(OP_RET, 0, 0, '0);
      `CHK("ret pc", exp_q[i], pc)
      pchk(0, 0, 5'(i - 1));
    end
    for (int h = 0; h < 2; h++) begin
      int_hi <= (h == 1);
      op_do(OP_NONE, 1, 0, '0);
      `CHK("vector", (h == 1) ? INT_HI_VEC : INT_LO_VEC, pc)
      pchk(0, 0, 5'h01);
      op_do(OP_POP, 0, 0, '0);
      `CHK("pop pc", (h == 1) ? INT_HI_VEC : INT_LO_VEC, pc)
      pchk(0, 0, '0);
    end
    $display("call return test done");
    op_do(OP_NONE, 0, 1, 21'h00_0abc);
    op_do(OP_PUSH, 0, 0, '0);
    tos_rd(t);
    `CHK("push tos", 21'h00_0abc, t)
    // no interrupt while the top entry is rewritten
    ax(1, OFF_TOS_UP, 32'h0000_0001);
    ax(1, OFF_TOS_HI, 32'h0000_0012);
    ax(1, OFF_TOS_LO, 32'h0000_0034);
    op_do(OP_RET, 0, 0, '0);
    `CHK("tos write", 21'h01_1234, pc)
    op_do(OP_RET, 0, 0, '0);
    `CHK("unf pc", RESET_VEC, pc)
    pchk(0, 1, '0);
    ax(0, OFF_CFG, '0);
    `CHK("cfg kept", CFG_RST, q)
    ax(1, OFF_PTR_REG, 32'h0000_00c0);
    pchk(0, 1, '0);
    ax(1, OFF_PTR_REG, 32'h0000_0015);
    pchk(0, 0, 5'h15);
    $display("top entry test done");
    ax(1, OFF_PTR_REG, '0);
    ax(1, OFF_CFG, '0);
    calls(31);
    pchk(1, 0, 5'h1f);
    op_do(OP_CALL, 0, 0, '0);
    pchk(1, 0, 5'h1f);
    tos_rd(t);
    `CHK("no overwrite", exp_q[31], t)
    ax(1, OFF_PTR_REG, '0);
    ax(1, OFF_CFG, CFG_RST);
    calls(31);
    pchk(1, 0, '0);
    `CHK("fault pulses", 1, faults)
    $display("full test done");
    ax(1, OFF_CFG, CFG_RST);
    fchk(21'h00_0ffe, mem(21'h00_0ffe));
    fchk(MEM_4K, 16'h0000);
    ax(1, OFF_CFG, 32'h0000_0003);
    fchk(MEM_4K, mem(MEM_4K));
    fchk(MEM_8K, 16'h0000);
    op_do(OP_NONE, 0, 1, 21'h1f_fffe);
    step <= 1;
    @(posedge clk);
    step <= 0;
    @(negedge clk);
    `CHK("pc wrap", 21'h00_0000, pc)
    `CHK("data addr", pc ^ 21'h15_5555, data_addr)
    ax(0, 8'h20, '0);
    `CHK("unmapped rd", RESP_ERR, rs)
    ax(1, 8'h24, 32'h0000_00ff);
    `CHK("unmapped wr", RESP_ERR, rs)
    $display("fetch and map test done");
    end_sim();
  end
endmodule // test_return_address_stack
